//--- pswr_pkg.sv
package pswr_pkg;

	localparam int ADDR_W  = 7;
	localparam int DATA_W  = 8;

	// register offsets on the serial link
	localparam logic [ADDR_W-1:0] OFS_DUTY_TWO  = 7'h19;
	localparam logic [ADDR_W-1:0] OFS_RATE_SEL  = 7'h1c;
	localparam logic [ADDR_W-1:0] OFS_SCRATCH   = 7'h1e;
	localparam logic [ADDR_W-1:0] OFS_WAKE_CTRL = 7'h20;
	localparam logic [ADDR_W-1:0] OFS_QUANTA    = 7'h21;
	localparam logic [ADDR_W-1:0] OFS_SAMPLE    = 7'h22;
	localparam logic [ADDR_W-1:0] OFS_ID_UPPER  = 7'h23;
	localparam logic [ADDR_W-1:0] OFS_ID_MIDHI  = 7'h24;
	localparam logic [ADDR_W-1:0] OFS_ID_MIDLO  = 7'h25;
	localparam logic [ADDR_W-1:0] OFS_ID_LOWER  = 7'h26;
	localparam logic [ADDR_W-1:0] OFS_LP_OPTION = 7'h35;

	// writable bits; everything else is reserved and reads zero
	localparam logic [DATA_W-1:0] MASK_FULL      = 8'hff;
	localparam logic [DATA_W-1:0] MASK_RATE_SEL  = 8'h05;
	localparam logic [DATA_W-1:0] MASK_WAKE_CTRL = 8'hf1;
	localparam logic [DATA_W-1:0] MASK_SAMPLE    = 8'h3f;
	localparam logic [DATA_W-1:0] MASK_ID_LOWER  = 8'h7f;
	localparam logic [DATA_W-1:0] MASK_LP_OPTION = 8'h01;

	localparam logic [DATA_W-1:0] RST_ZERO    = 8'h00;
	localparam logic [DATA_W-1:0] RST_QUANTA  = 8'ha0;
	localparam logic [DATA_W-1:0] RST_SAMPLE  = 8'h33;

	// field positions
	localparam int RATE_ONE_BIT   = 0;
	localparam int RATE_TWO_BIT   = 2;
	localparam int OSC_TRIM_BIT   = 7;
	localparam int TRIM_HI_BIT    = 6;
	localparam int TRIM_LO_BIT    = 5;
	localparam int TO_IRQ_EN_BIT  = 4;
	localparam int CFG_VALID_BIT  = 0;
	localparam int SAMPLE_HI_BIT  = 5;
	localparam int ID_LOW_HI_BIT  = 6;
	localparam int ID_LOW_LO_BIT  = 2;
	localparam int RTR_BIT        = 1;
	localparam int IDE_BIT        = 0;
	localparam int LP_RX_BIT      = 0;
	localparam int ID_W           = 29;

	localparam logic [1:0] TRIM_UNLOCK    = 2'h3;
	localparam logic [2:0] HS_FROM_PULSE2 = 3'h5;

	// serial frame: address lsb first, write flag, then data
	localparam int SPI_FRAME_BITS = 16;
	localparam int SPI_WRITE_BIT  = 7;
	localparam int SPI_DATA_LO    = 8;
	localparam int SPI_CNT_W      = 5;

	// pulse generator timing
	localparam int CLK_HZ        = 250_000_000;
	localparam int RATE_SLOW_HZ  = 200;
	localparam int RATE_FAST_HZ  = 400;
	localparam int DUTY_STEPS    = 255;
	localparam logic [DATA_W-1:0] DUTY_FULL = 8'hff;
	localparam logic [DATA_W-1:0] PHASE_LAST = 8'hfe;
	localparam int STEP_SLOW_CYC = CLK_HZ / (RATE_SLOW_HZ * DUTY_STEPS);
	localparam int STEP_FAST_CYC = CLK_HZ / (RATE_FAST_HZ * DUTY_STEPS);
	localparam int STEP_CNT_W    = 13;
	localparam int PULSE_COUNT   = 2;

endpackage : pswr_pkg

//--- pswr_pulse_if.sv
`timescale 1ns/1ps
interface pswr_pulse_if;
	logic [7:0] duty;
	logic       rateFast;
	logic       pulseOut;

	modport ctl (output duty, output rateFast, input pulseOut);
	modport gen (input duty, input rateFast, output pulseOut);
endinterface : pswr_pulse_if

//--- pswr_pulse_gen.sv
`timescale 1ns/1ps
module pswr_pulse_gen
	import pswr_pkg::*;
#(
	parameter int STEP_SLOW = STEP_SLOW_CYC,
	parameter int STEP_FAST = STEP_FAST_CYC
)
(
	input wire logic   clk,
	input wire logic   sys_rst,
	pswr_pulse_if.gen  port
);

	localparam logic [STEP_CNT_W-1:0] SLOW_LAST = STEP_CNT_W'(STEP_SLOW - 1);
	localparam logic [STEP_CNT_W-1:0] FAST_LAST = STEP_CNT_W'(STEP_FAST - 1);

	logic [STEP_CNT_W-1:0] stepCnt_q;
	logic [STEP_CNT_W-1:0] stepCnt_d;
	logic [DATA_W-1:0]     phase_q;
	logic [DATA_W-1:0]     phase_d;
	logic                  pulse_q;
	logic                  pulse_d;
	logic                  stepTick;

	always_comb
	begin
		// one period is 255 steps, so duty/255 of it is on
		stepTick  = (stepCnt_q >= (port.rateFast ? FAST_LAST : SLOW_LAST));
		stepCnt_d = stepTick ? '0 : stepCnt_q + STEP_CNT_W'(1);
		phase_d   = phase_q;
		if (stepTick)
		begin
			phase_d = (phase_q >= PHASE_LAST) ? '0 : phase_q + DATA_W'(1);
		end
		pulse_d = (port.duty == DUTY_FULL) || (phase_q < port.duty);
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			stepCnt_q <= '0;
			phase_q   <= '0;
			pulse_q   <= 1'b0;
		end
		else
		begin
			stepCnt_q <= stepCnt_d;
			phase_q   <= phase_d;
			pulse_q   <= pulse_d;
		end
	end

	assign port.pulseOut = pulse_q;

endmodule : pswr_pulse_gen

//--- pswr_regs.sv
`timescale 1ns/1ps
// Functional notes
// - second generator off at duty 0, on at 255, else on duty/255 of period.
// - rate bit clear gives 200 Hz, set gives 400 Hz; bit 0 first, bit 2 second.
// - reserved bit positions always read back as zero.
// - scratch byte cleared at power-up, kept across soft reset.
// - scratch byte reachable only in normal mode; internal logic never uses it.
// - scratch byte survives fail-safe and restart mode transitions.
// - control bit 7 enables oscillator calibration mode.
// - trim unlock field unlocks only for pattern 11.
// - unlocked calibration uses the bus transmit input as trimming reference.
// - low-power receiver option writes accepted only while trim field is 11.
// - bus timeout raises interrupt only when control bit 4 is one.
// - timeout flag sets only with selective wake mode, clears in any mode; irq in normal/stop.
// - selective wake enabled only while configuration-valid bit is one.
// - valid bit clears on wake-up, power-on, and any wake config change.
// - quanta-per-bit register, reset value 0xa0.
// - six-bit sample point fraction, reset value 0x33.
// - 29-bit identifier built from four registers, low bits at 6:2.
// - lowest identifier register bit 1 is the remote request flag.
// - lowest identifier register bit 0 is the extended identifier flag.
// - high-side switch follows second generator when its config is 101.
module pswr_regs
	import pswr_pkg::*;
#(
	parameter int STEP_SLOW = STEP_SLOW_CYC,
	parameter int STEP_FAST = STEP_FAST_CYC
)
(
	input  wire logic              clk,
	input  wire logic              sys_rst,
	input  wire logic              spiSck,
	input  wire logic              spiCsN,
	input  wire logic              spiMosi,
	output wire logic              spiMiso,
	output wire logic              spiMisoOe,
	input  wire logic              softReset,
	input  wire logic              normalMode,
	input  wire logic              stopMode,
	input  wire logic              transceiverSwkMode,
	input  wire logic              wakeEvent,
	input  wire logic              busTimeoutEvent,
	input  wire logic              busTimeoutClear,
	input  wire logic              busTransmitInput,
	input  wire logic [DATA_W-1:0] firstPulseDuty,
	input  wire logic [2:0]        highSideConfig,
	output wire logic              firstPulseOut,
	output wire logic              secondPulseOut,
	output wire logic              highSideDrive,
	output wire logic              timeoutIrq,
	output wire logic              busTimeoutFlag,
	output wire logic              oscTrimEnable,
	output wire logic              trimReference,
	output wire logic              selectiveWakeEnable,
	output wire logic              lowPowerReceiverSelect,
	output wire logic [DATA_W-1:0] quantaPerBit,
	output wire logic [5:0]        samplePoint,
	output wire logic [ID_W-1:0]   wakeIdentifier,
	output wire logic              remoteRequest,
	output wire logic              idExtended
);

	// pins from outside: sck, chip select, mosi, bus transmit input
	localparam int PIN_N   = 4;
	localparam int PIN_SCK = 0;
	localparam int PIN_CS  = 1;
	localparam int PIN_SDI = 2;
	localparam int PIN_TX  = 3;

	logic [PIN_N-1:0] pinMeta_q;
	logic [PIN_N-1:0] pinSync_q;
	logic [PIN_N-1:0] pinRaw;

	assign pinRaw = {busTransmitInput, spiMosi, spiCsN, spiSck};

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			pinMeta_q <= {1'b0, 1'b0, 1'b1, 1'b0};
			pinSync_q <= {1'b0, 1'b0, 1'b1, 1'b0};
		end
		else
		begin
			pinMeta_q <= pinRaw;
			pinSync_q <= pinMeta_q;
		end
	end

	// register file
	logic [DATA_W-1:0] dutyTwo_q,   dutyTwo_d;
	logic [DATA_W-1:0] rateSel_q,   rateSel_d;
	logic [DATA_W-1:0] scratch_q,   scratch_d;
	logic [DATA_W-1:0] wakeCtrl_q,  wakeCtrl_d;
	logic [DATA_W-1:0] quanta_q,    quanta_d;
	logic [DATA_W-1:0] sample_q,    sample_d;
	logic [DATA_W-1:0] idUpper_q,   idUpper_d;
	logic [DATA_W-1:0] idMidHi_q,   idMidHi_d;
	logic [DATA_W-1:0] idMidLo_q,   idMidLo_d;
	logic [DATA_W-1:0] idLower_q,   idLower_d;
	logic [DATA_W-1:0] lpOption_q,  lpOption_d;
	logic              toFlag_q,    toFlag_d;
	logic              toIrq_q,     toIrq_d;
	logic              trimRef_q,   trimRef_d;
	logic              hsDrive_q,   hsDrive_d;

	logic              trimUnlocked;

	pswr_pulse_if pulseBus [PULSE_COUNT] ();

	assign trimUnlocked = (wakeCtrl_q[TRIM_HI_BIT:TRIM_LO_BIT] == TRIM_UNLOCK);

	function automatic logic [DATA_W-1:0] readReg(input logic [ADDR_W-1:0] addr);
		logic [DATA_W-1:0] val;
		val = '0;
		unique case (addr)
			OFS_DUTY_TWO:  val = dutyTwo_q;
			OFS_RATE_SEL:  val = rateSel_q & MASK_RATE_SEL;
			OFS_SCRATCH:   val = normalMode ? scratch_q : RST_ZERO;
			OFS_WAKE_CTRL: val = wakeCtrl_q & MASK_WAKE_CTRL;
			OFS_QUANTA:    val = quanta_q;
			OFS_SAMPLE:    val = sample_q & MASK_SAMPLE;
			OFS_ID_UPPER:  val = idUpper_q;
			OFS_ID_MIDHI:  val = idMidHi_q;
			OFS_ID_MIDLO:  val = idMidLo_q;
			OFS_ID_LOWER:  val = idLower_q & MASK_ID_LOWER;
			OFS_LP_OPTION: val = lpOption_q & MASK_LP_OPTION;
			default:       val = '0;
		endcase
		return val;
	endfunction : readReg

	// any write here counts as a change of wake configuration
	function automatic logic isWakeConfig(input logic [ADDR_W-1:0] addr);
		return (addr >= OFS_QUANTA && addr <= OFS_ID_LOWER) || (addr == OFS_LP_OPTION);
	endfunction : isWakeConfig

	// serial slave: mode 0, lsb first, 16-bit frames committed on chip select release
	logic [SPI_CNT_W-1:0]      bitCnt_q,   bitCnt_d;
	logic [SPI_FRAME_BITS-1:0] shift_q,    shift_d;
	logic [DATA_W-1:0]         misoSh_q,   misoSh_d;
	logic                      miso_q,     miso_d;
	logic                      sckPrev_q,  sckPrev_d;
	logic                      csPrev_q,   csPrev_d;
	logic                      sckRise;
	logic                      sckFall;
	logic                      csActive;
	logic                      frameEnd;
	logic                      wrEn;
	logic [ADDR_W-1:0]         wrAddr;
	logic [DATA_W-1:0]         wrData;

	assign csActive = ~pinSync_q[PIN_CS];
	assign sckRise  = pinSync_q[PIN_SCK] & ~sckPrev_q;
	assign sckFall  = ~pinSync_q[PIN_SCK] & sckPrev_q;
	assign frameEnd = pinSync_q[PIN_CS] & ~csPrev_q;
	assign wrAddr   = shift_q[ADDR_W-1:0];
	assign wrData   = shift_q[SPI_FRAME_BITS-1:SPI_DATA_LO];
	// short or long frames are dropped whole
	assign wrEn     = frameEnd && (bitCnt_q == SPI_CNT_W'(SPI_FRAME_BITS)) && shift_q[SPI_WRITE_BIT];

	always_comb
	begin
		sckPrev_d = pinSync_q[PIN_SCK];
		csPrev_d  = pinSync_q[PIN_CS];
		bitCnt_d  = bitCnt_q;
		shift_d   = shift_q;
		misoSh_d  = misoSh_q;
		miso_d    = miso_q;
		if (!csActive)
		begin
			bitCnt_d = '0;
			misoSh_d = '0;
			miso_d   = 1'b0;
		end
		else
		begin
			if (sckRise)
			begin
				shift_d = {pinSync_q[PIN_SDI], shift_q[SPI_FRAME_BITS-1:1]};
				if (bitCnt_q != '1)
				begin
					bitCnt_d = bitCnt_q + SPI_CNT_W'(1);
				end
				if (bitCnt_q == SPI_CNT_W'(SPI_DATA_LO - 1))
				begin
					// after eight rises the address sits just below the write flag
					misoSh_d = readReg(shift_d[SPI_DATA_LO +: ADDR_W]);
				end
			end
			if (sckFall && bitCnt_q >= SPI_CNT_W'(SPI_DATA_LO))
			begin
				miso_d   = misoSh_q[0];
				misoSh_d = misoSh_q >> 1;
			end
		end
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			bitCnt_q  <= '0;
			shift_q   <= '0;
			misoSh_q  <= '0;
			miso_q    <= 1'b0;
			sckPrev_q <= 1'b0;
			csPrev_q  <= 1'b1;
		end
		else
		begin
			bitCnt_q  <= bitCnt_d;
			shift_q   <= shift_d;
			misoSh_q  <= misoSh_d;
			miso_q    <= miso_d;
			sckPrev_q <= sckPrev_d;
			csPrev_q  <= csPrev_d;
		end
	end

	// register updates; restart mode has no input so contents are simply held
	always_comb
	begin
		dutyTwo_d  = dutyTwo_q;
		rateSel_d  = rateSel_q;
		scratch_d  = scratch_q;
		wakeCtrl_d = wakeCtrl_q;
		quanta_d   = quanta_q;
		sample_d   = sample_q;
		idUpper_d  = idUpper_q;
		idMidHi_d  = idMidHi_q;
		idMidLo_d  = idMidLo_q;
		idLower_d  = idLower_q;
		lpOption_d = lpOption_q;
		if (wrEn)
		begin
			unique case (wrAddr)
				OFS_DUTY_TWO:  dutyTwo_d  = wrData;
				OFS_RATE_SEL:  rateSel_d  = wrData & MASK_RATE_SEL;
				OFS_SCRATCH:
				begin
					if (normalMode)
					begin
						scratch_d = wrData;
					end
				end
				OFS_WAKE_CTRL: wakeCtrl_d = wrData & MASK_WAKE_CTRL;
				OFS_QUANTA:    quanta_d   = wrData;
				OFS_SAMPLE:    sample_d   = wrData & MASK_SAMPLE;
				OFS_ID_UPPER:  idUpper_d  = wrData;
				OFS_ID_MIDHI:  idMidHi_d  = wrData;
				OFS_ID_MIDLO:  idMidLo_d  = wrData;
				OFS_ID_LOWER:  idLower_d  = wrData & MASK_ID_LOWER;
				OFS_LP_OPTION:
				begin
					if (trimUnlocked)
					begin
						lpOption_d = wrData & MASK_LP_OPTION;
					end
				end
				default: ;
			endcase
			if (isWakeConfig(wrAddr))
			begin
				wakeCtrl_d[CFG_VALID_BIT] = 1'b0;
			end
		end
		// a wake beats a simultaneous software set of the valid bit
		if (wakeEvent)
		begin
			wakeCtrl_d[CFG_VALID_BIT] = 1'b0;
		end
		// scratch byte is deliberately left out of soft reset
		if (softReset)
		begin
			dutyTwo_d  = RST_ZERO;
			rateSel_d  = RST_ZERO;
			wakeCtrl_d = RST_ZERO;
			quanta_d   = RST_QUANTA;
			sample_d   = RST_SAMPLE;
			idUpper_d  = RST_ZERO;
			idMidHi_d  = RST_ZERO;
			idMidLo_d  = RST_ZERO;
			idLower_d  = RST_ZERO;
			lpOption_d = RST_ZERO;
		end
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			dutyTwo_q  <= RST_ZERO;
			rateSel_q  <= RST_ZERO;
			scratch_q  <= RST_ZERO;
			wakeCtrl_q <= RST_ZERO;
			quanta_q   <= RST_QUANTA;
			sample_q   <= RST_SAMPLE;
			idUpper_q  <= RST_ZERO;
			idMidHi_q  <= RST_ZERO;
			idMidLo_q  <= RST_ZERO;
			idLower_q  <= RST_ZERO;
			lpOption_q <= RST_ZERO;
		end
		else
		begin
			dutyTwo_q  <= dutyTwo_d;
			rateSel_q  <= rateSel_d;
			scratch_q  <= scratch_d;
			wakeCtrl_q <= wakeCtrl_d;
			quanta_q   <= quanta_d;
			sample_q   <= sample_d;
			idUpper_q  <= idUpper_d;
			idMidHi_q  <= idMidHi_d;
			idMidLo_q  <= idMidLo_d;
			idLower_q  <= idLower_d;
			lpOption_q <= lpOption_d;
		end
	end

	// timeout, trim reference and switch drive
	always_comb
	begin
		toFlag_d = toFlag_q;
		if (busTimeoutClear || softReset)
		begin
			toFlag_d = 1'b0;
		end
		if (busTimeoutEvent && transceiverSwkMode)
		begin
			toFlag_d = 1'b1;
		end
		toIrq_d = busTimeoutEvent && transceiverSwkMode && (normalMode || stopMode)
			&& wakeCtrl_q[TO_IRQ_EN_BIT];
		// trimming follows the pin only when enabled and unlocked
		trimRef_d = oscTrimEnable & pinSync_q[PIN_TX];
		hsDrive_d = (highSideConfig == HS_FROM_PULSE2) & pulseBus[1].pulseOut;
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			toFlag_q  <= 1'b0;
			toIrq_q   <= 1'b0;
			trimRef_q <= 1'b0;
			hsDrive_q <= 1'b0;
		end
		else
		begin
			toFlag_q  <= toFlag_d;
			toIrq_q   <= toIrq_d;
			trimRef_q <= trimRef_d;
			hsDrive_q <= hsDrive_d;
		end
	end

	// pulse generators
	logic [DATA_W-1:0] genDuty [PULSE_COUNT];
	logic              genFast [PULSE_COUNT];

	assign genDuty[0] = firstPulseDuty;
	assign genDuty[1] = dutyTwo_q;
	assign genFast[0] = rateSel_q[RATE_ONE_BIT];
	assign genFast[1] = rateSel_q[RATE_TWO_BIT];

	genvar g;
	generate
		for (g = 0; g < PULSE_COUNT; g++)
		begin : gen_pulse
			assign pulseBus[g].duty     = genDuty[g];
			assign pulseBus[g].rateFast = genFast[g];
			pswr_pulse_gen #(
				.STEP_SLOW (STEP_SLOW),
				.STEP_FAST (STEP_FAST)
			) u_gen (
				.clk     (clk),
				.sys_rst (sys_rst),
				.port    (pulseBus[g])
			);
		end
	endgenerate

	assign firstPulseOut          = pulseBus[0].pulseOut;
	assign secondPulseOut         = pulseBus[1].pulseOut;
	assign highSideDrive          = hsDrive_q;
	assign timeoutIrq             = toIrq_q;
	assign busTimeoutFlag         = toFlag_q;
	assign oscTrimEnable          = wakeCtrl_q[OSC_TRIM_BIT] & trimUnlocked;
	assign trimReference          = trimRef_q;
	assign selectiveWakeEnable    = wakeCtrl_q[CFG_VALID_BIT] & transceiverSwkMode;
	assign lowPowerReceiverSelect = lpOption_q[LP_RX_BIT];
	assign quantaPerBit           = quanta_q;
	assign samplePoint            = sample_q[SAMPLE_HI_BIT:0];
	assign wakeIdentifier         = {idUpper_q, idMidHi_q, idMidLo_q,
		idLower_q[ID_LOW_HI_BIT:ID_LOW_LO_BIT]};
	assign remoteRequest          = idLower_q[RTR_BIT];
	assign idExtended             = idLower_q[IDE_BIT];
	assign spiMiso                = miso_q;
	assign spiMisoOe              = csActive;

endmodule : pswr_regs

//--- pswr_spi_host.sv
`timescale 1ns/1ps
module pswr_spi_host
(
	input  wire logic clk,
	input  wire logic miso,
	output logic      sck,
	output logic      csN,
	output logic      mosi,
	output logic      txRef
);
	initial
	begin
		sck = 1'b0;
		csN = 1'b1;
		mosi = 1'b0;
		txRef = 1'b0;
	end

	// mode 0 master, lsb first; 5-clk phases leave margin over the pin synchronisers
	task automatic xfer(input logic [6:0] addr, input logic wr, input logic [7:0] wdata, input int nBits,
		output logic [7:0] rdata);
		logic [15:0] frame;
		frame = {wdata, wr, addr};
		rdata = 8'h00;
		@(negedge clk);
		csN = 1'b0;
		for (int i = 0; i < nBits; i++)
		begin
			mosi = frame[i];
			repeat (5) @(negedge clk);
			sck = 1'b1;
			if (i >= 8)
				rdata[i-8] = miso;
			repeat (5) @(negedge clk);
			sck = 1'b0;
		end
		repeat (3) @(negedge clk);
		csN = 1'b1;
		// released data line must not keep its last level
		mosi = ~mosi;
		repeat (8) @(negedge clk);
	endtask : xfer

	task automatic setTx(input logic v);
		@(negedge clk);
		txRef = v;
	endtask : setTx
endmodule : pswr_spi_host

//--- pswr_regs_monitor.sv
`timescale 1ns/1ps
module pswr_regs_monitor
	import pswr_pkg::*;
#(
	parameter int STEP_SLOW = STEP_SLOW_CYC,
	parameter int STEP_FAST = STEP_FAST_CYC
)
(
	input wire logic              clk,
	input wire logic              sys_rst,
	input wire logic              spiCsN,
	input wire logic              softReset,
	input wire logic              normalMode,
	input wire logic              stopMode,
	input wire logic              transceiverSwkMode,
	input wire logic              wakeEvent,
	input wire logic              busTimeoutEvent,
	input wire logic [DATA_W-1:0] firstPulseDuty,
	input wire logic [2:0]        highSideConfig,
	input wire logic              firstPulseOut,
	input wire logic              secondPulseOut,
	input wire logic              highSideDrive,
	input wire logic              timeoutIrq,
	input wire logic              busTimeoutFlag,
	input wire logic              oscTrimEnable,
	input wire logic              trimReference,
	input wire logic              selectiveWakeEnable,
	input wire logic [ID_W-1:0]   wakeIdentifier
);
	default clocking mcb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	a_irq_has_cause: assert property (timeoutIrq |-> $past(busTimeoutEvent) && $past(transceiverSwkMode)
		&& ($past(normalMode) || $past(stopMode))) else $error("timeout irq without a qualifying event");
	a_irq_one_cycle: assert property (timeoutIrq && !busTimeoutEvent |=> !timeoutIrq)
		else $error("timeout irq longer than one cycle");
	a_flag_sets: assert property (busTimeoutEvent && transceiverSwkMode && !softReset |=> busTimeoutFlag)
		else $error("timeout flag not set by event");
	a_flag_cause: assert property ($rose(busTimeoutFlag) |-> $past(busTimeoutEvent) && $past(transceiverSwkMode))
		else $error("timeout flag set outside selective wake mode");
	a_swk_needs_mode: assert property (!transceiverSwkMode && !$past(transceiverSwkMode) |-> !selectiveWakeEnable)
		else $error("selective wake enabled without mode bit");
	a_wake_drops_valid: assert property (wakeEvent |-> ##[1:2] !selectiveWakeEnable)
		else $error("wake event left selective wake enabled");
	a_trim_ref_gated: assert property (!oscTrimEnable && !$past(oscTrimEnable) |-> !trimReference)
		else $error("trim reference active while trimming locked");
	a_hs_follows: assert property (highSideConfig == HS_FROM_PULSE2 && $past(highSideConfig) == HS_FROM_PULSE2
		|-> highSideDrive == secondPulseOut || highSideDrive == $past(secondPulseOut))
		else $error("high-side drive does not follow second generator");
	a_duty_full_on: assert property ((firstPulseDuty == 8'hff) [*4] |-> firstPulseOut)
		else $error("full duty output not constantly on");
	a_duty_zero_off: assert property ((firstPulseDuty == 8'h00) [*4] |-> !firstPulseOut)
		else $error("zero duty output not constantly off");
	a_id_at_rest: assert property (!$stable(wakeIdentifier) |-> spiCsN || $past(softReset))
		else $error("identifier changed during a frame");
endmodule : pswr_regs_monitor

bind pswr_regs pswr_regs_monitor #(.STEP_SLOW(STEP_SLOW), .STEP_FAST(STEP_FAST)) pswr_regs_monitor_i (
	.clk(clk), .sys_rst(sys_rst), .spiCsN(spiCsN), .softReset(softReset), .normalMode(normalMode),
	.stopMode(stopMode), .transceiverSwkMode(transceiverSwkMode), .wakeEvent(wakeEvent),
	.busTimeoutEvent(busTimeoutEvent), .firstPulseDuty(firstPulseDuty), .highSideConfig(highSideConfig),
	.firstPulseOut(firstPulseOut), .secondPulseOut(secondPulseOut), .highSideDrive(highSideDrive),
	.timeoutIrq(timeoutIrq), .busTimeoutFlag(busTimeoutFlag), .oscTrimEnable(oscTrimEnable),
	.trimReference(trimReference), .selectiveWakeEnable(selectiveWakeEnable), .wakeIdentifier(wakeIdentifier));

//--- pswr_regs_tb.sv
`timescale 1ns/1ps
module pswr_regs_tb
	import pswr_pkg::*;
;
	localparam int SS = 8;
	localparam int SF = 4;
	localparam logic [6:0] OFS [10] = '{OFS_DUTY_TWO, OFS_RATE_SEL, OFS_SCRATCH, OFS_WAKE_CTRL, OFS_QUANTA,
		OFS_SAMPLE, OFS_ID_UPPER, OFS_ID_MIDHI, OFS_ID_MIDLO, OFS_ID_LOWER};
	localparam logic [7:0] RSTV [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'ha0, 8'h33, 8'h00, 8'h00, 8'h00, 8'h00};
	localparam logic [7:0] WRV [10] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hb4, 8'hff, 8'hff, 8'hfd};
	// valid bit of 0x20 is cleared again by the later quanta, sample and id writes
	localparam logic [7:0] EXPV [10] = '{8'hff, 8'h05, 8'hff, 8'hf0, 8'hff, 8'h3f, 8'hb4, 8'hff, 8'hff, 8'h7d};
	// {irq enable, swk mode, normal, stop, irq expected, flag expected}
	localparam logic [5:0] TOV [5] = '{6'b111011, 6'b011001, 6'b101000, 6'b110111, 6'b110001};
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic softReset = 1'b0, normalMode = 1'b1, stopMode = 1'b0, swkMode = 1'b0;
	logic wakeEv = 1'b0, toEv = 1'b0, toClr = 1'b0;
	logic [7:0] p1Duty = 8'h00;
	logic [2:0] hsCfg = HS_FROM_PULSE2;
	logic spiSck, spiCsN, spiMosi, spiMiso, txPin, p1Out, p2Out, hsOut, irq, toFlag, trimEn, trimRef, swkEn;
	logic lpSel, rtr, ide, misoOe;
	logic [7:0] quanta;
	logic [5:0] sample;
	logic [ID_W-1:0] wakeId;
	int bad_count = 0;
	int cmp_count = 0;
	int irqCount = 0;

	always #2 clk = ~clk;
	always @(negedge clk) if (irq === 1'b1) irqCount++;

	pswr_regs #(.STEP_SLOW(SS), .STEP_FAST(SF)) pswr_regs_i (
		.clk(clk), .sys_rst(sys_rst), .spiSck(spiSck), .spiCsN(spiCsN), .spiMosi(spiMosi), .spiMiso(spiMiso),
		.spiMisoOe(misoOe), .softReset(softReset), .normalMode(normalMode), .stopMode(stopMode),
		.transceiverSwkMode(swkMode), .wakeEvent(wakeEv), .busTimeoutEvent(toEv), .busTimeoutClear(toClr),
		.busTransmitInput(txPin), .firstPulseDuty(p1Duty), .highSideConfig(hsCfg), .firstPulseOut(p1Out),
		.secondPulseOut(p2Out), .highSideDrive(hsOut), .timeoutIrq(irq), .busTimeoutFlag(toFlag),
		.oscTrimEnable(trimEn), .trimReference(trimRef), .selectiveWakeEnable(swkEn),
		.lowPowerReceiverSelect(lpSel), .quantaPerBit(quanta), .samplePoint(sample), .wakeIdentifier(wakeId),
		.remoteRequest(rtr), .idExtended(ide));

	pswr_spi_host pswr_spi_host_i (.clk(clk), .miso(spiMiso), .sck(spiSck), .csN(spiCsN), .mosi(spiMosi),
		.txRef(txPin));

	task conclude();
		$display("bad_count=%0d cmp_count=%0d", bad_count, cmp_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : conclude

	task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		cmp_count++;
		if (got !== exp)
		begin
			bad_count++;
			$display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk

	task wr(input logic [6:0] a, input logic [7:0] d);
		logic [7:0] r;
		pswr_spi_host_i.xfer(a, 1'b1, d, 16, r);
	endtask : wr

	task rd(input logic [6:0] a, input logic [7:0] e);
		logic [7:0] r;
		pswr_spi_host_i.xfer(a, 1'b0, 8'h00, 16, r);
		chk(r, e, $sformatf("read %h", a));
	endtask : rd

	task automatic pulse(ref logic s);
		@(negedge clk);
		s = 1'b1;
		@(negedge clk);
		s = 1'b0;
		repeat (2) @(negedge clk);
	endtask : pulse

	function automatic logic pout(input logic s);
		return s ? p2Out : p1Out;
	endfunction : pout

	// one full period from a rising edge; high and total cycle counts
	task automatic measure(input logic s, output int hi, output int per);
		logic prev;
		int n;
		hi = 0;
		per = 0;
		n = 0;
		prev = 1'b1;
		while (!(prev === 1'b0 && pout(s) === 1'b1) && n < 6000)
		begin
			prev = pout(s);
			@(negedge clk);
			n++;
		end
		do
		begin
			hi += (pout(s) === 1'b1);
			per++;
			prev = pout(s);
			@(negedge clk);
		end
		while (!(prev === 1'b0 && pout(s) === 1'b1) && per < 6000);
		if (n >= 6000 || per >= 6000)
		begin
			bad_count++;
			$display("[FAIL] %0t pulse output stuck", $time);
			conclude();
		end
	endtask : measure

	initial
	begin
		repeat (50000) @(posedge clk);
		bad_count++;
		$display("[FAIL] %0t run limit reached", $time);
		conclude();
	end

	initial
	begin
		int hi, per, n, st;
		logic [7:0] r;
		repeat (2) @(negedge clk);
		sys_rst = 1'b0;
		repeat (4) @(negedge clk);
		for (int i = 0; i < 10; i++) rd(OFS[i], RSTV[i]);
		$display("reset values done");
		for (int i = 0; i < 10; i++) wr(OFS[i], WRV[i]);
		for (int i = 0; i < 10; i++) rd(OFS[i], EXPV[i]);
		rd(7'h7f, 8'h00);
		chk(misoOe, 1'b0, "miso enable idle");
		chk(quanta, 8'hff, "quanta");
		chk(sample, 6'h3f, "sample");
		chk(wakeId, {8'hb4, 8'hff, 8'hff, 5'h1f}, "id");
		chk(rtr, 1'b0, "rtr");
		chk(ide, 1'b1, "ide");
		$display("readback done");
		for (int p = 0; p < 4; p++)
		begin
			wr(OFS_WAKE_CTRL, {1'b1, p[1:0], 5'h00});
			chk(trimEn, p == 3, "trim enable");
			wr(OFS_LP_OPTION, 8'h01);
			rd(OFS_LP_OPTION, {7'h00, p == 3});
			chk(lpSel, p == 3, "lp select");
		end
		for (int v = 1; v >= 0; v--)
		begin
			pswr_spi_host_i.setTx(v[0]);
			repeat (6) @(negedge clk);
			chk(trimRef, v[0], "trim ref");
		end
		wr(OFS_WAKE_CTRL, 8'h60);
		chk(trimEn, 1'b0, "trim off");
		pswr_spi_host_i.setTx(1'b1);
		repeat (6) @(negedge clk);
		chk(trimRef, 1'b0, "ref locked");
		$display("trim done");
		swkMode = 1'b1;
		wr(OFS_WAKE_CTRL, 8'h11);
		chk(swkEn, 1'b1, "swk enable");
		for (int i = 0; i < 5; i++)
		begin
			{swkMode, normalMode, stopMode} = TOV[i][4:2];
			wr(OFS_WAKE_CTRL, {3'h0, TOV[i][5], 4'h1});
			pulse(toClr);
			n = irqCount;
			pulse(toEv);
			chk(irqCount - n, TOV[i][1], "irq count");
			chk(toFlag, TOV[i][0], "timeout flag");
		end
		{swkMode, normalMode, stopMode} = 3'b110;
		wr(OFS_WAKE_CTRL, 8'h11);
		pulse(wakeEv);
		chk(swkEn, 1'b0, "wake clears");
		rd(OFS_WAKE_CTRL, 8'h10);
		wr(OFS_WAKE_CTRL, 8'h11);
		wr(OFS_ID_UPPER, 8'h12);
		rd(OFS_WAKE_CTRL, 8'h10);
		$display("wake control done");
		wr(OFS_SCRATCH, 8'h5a);
		normalMode = 1'b0;
		rd(OFS_SCRATCH, 8'h00);
		wr(OFS_SCRATCH, 8'ha5);
		normalMode = 1'b1;
		rd(OFS_SCRATCH, 8'h5a);
		wr(OFS_QUANTA, 8'h11);
		pulse(softReset);
		rd(OFS_SCRATCH, 8'h5a);
		rd(OFS_QUANTA, 8'ha0);
		$display("scratch done");
		wr(OFS_DUTY_TWO, 8'h80);
		pswr_spi_host_i.xfer(OFS_DUTY_TWO, 1'b1, 8'h33, 15, r);
		rd(OFS_DUTY_TWO, 8'h80);
		p1Duty = 8'h40;
		for (int f = 0; f < 2; f++)
		begin
			st = f ? SF : SS;
			wr(OFS_RATE_SEL, {5'h00, f[0], 1'b0, f[0]});
			measure(1'b1, hi, per);
			chk(hi, 128 * st, "duty two high");
			chk(per, 255 * st, "period two");
			measure(1'b0, hi, per);
			chk(hi, 64 * st, "duty one high");
			chk(per, 255 * st, "period one");
		end
		for (int d = 0; d < 2; d++)
		begin
			wr(OFS_DUTY_TWO, d ? 8'h00 : 8'hff);
			p1Duty = d ? 8'h00 : 8'hff;
			n = 0;
			repeat (1100) @(negedge clk) n += (p2Out !== !d[0]);
			chk(n, 0, "duty boundary");
			chk(hsOut, !d[0], "switch drive");
			hsCfg = 3'h4;
			repeat (3) @(negedge clk);
			chk(hsOut, 1'b0, "switch other source");
			hsCfg = HS_FROM_PULSE2;
		end
		$display("pulse done");
		sys_rst = 1'b1;
		repeat (2) @(negedge clk);
		sys_rst = 1'b0;
		repeat (4) @(negedge clk);
		rd(OFS_SCRATCH, 8'h00);
		rd(OFS_SAMPLE, 8'h33);
		$display("power-on reset done");
		conclude();
	end
endmodule : pswr_regs_tb
